/* design/sml_map.svh */
// constants for the secure microcode loader: codes, widths, presets
// assumes inclusion from the loader package and the loader module only
`ifndef SML_MAP_SVH
`define SML_MAP_SVH
`define SML_BLK_W 64
`define SML_CRC_W 16
`define SML_CRC_INIT 16'hFFFF
`define SML_CRC_POLY 16'h1021
`define SML_MIN_BLOCKS 2
`define SML_KEY_BLOCKS 2
`define SML_CODE_NONE 2'h0
`define SML_CODE_AUTH 2'h1
`define SML_CODE_CRC 2'h2
`define SML_CODE_LEN 2'h3
`endif

/* design/sml_pkg.sv */
// types shared by the secure microcode loader files
// assumes sml_map.svh is on the include path
`include "sml_map.svh"
package sml_pkg;
    // one 64-bit block of an encrypted segment as delivered by the host
    typedef struct packed {
        logic [`SML_BLK_W-1:0] data;
        logic seg_last;   // this beat is the digest closing the segment
        logic set_last;   // segment closes the update set
        logic key_seg;    // segment carries replacement keys
    } sml_beat_s;
    typedef enum logic [2:0] {
        SML_RECV = 3'h0,
        SML_AUTH = 3'h1,
        SML_SEED = 3'h2,
        SML_FETCH = 3'h3,
        SML_DES = 3'h4,
        SML_EMIT = 3'h5,
        SML_END = 3'h6
    } sml_state_e;
    typedef logic [1:0] sml_code_t;
endpackage : sml_pkg

/* design/sml_seg_ram.sv */
// segment store: simple dual-port memory with registered read data
// assumes one clock; write and read may address the same word
`timescale 1ns/100ps
`default_nettype none
module sml_seg_ram #(
    parameter int W = 64,
    parameter int AW = 8
) (
    input wire logic clk_sys, // core clock
    input wire logic we, // write strobe
    input wire logic [AW-1:0] waddr, // write address
    input wire logic [W-1:0] wdata, // write data
    input wire logic re, // read strobe
    input wire logic [AW-1:0] raddr, // read address
    output logic [W-1:0] rdata // read data, one cycle after re
);
    logic [W-1:0] mem [0:(1<<AW)-1];
    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        if (re) begin
            rdata <= mem[raddr];
        end
    end
endmodule : sml_seg_ram
`default_nettype wire

/* design/sml_loader.sv */
// secure microcode loader: buffers host segments, authenticates them,
// decrypts them with chained DES and checks a CCITT checksum
// assumes external DES and digest engines on the same clock
//
// Overview of operation
// - each segment is decrypted with CBC-DES using an internal key.
// - a random chaining seed leads each segment; it seeds the chain.
// - the digest is checked before any segment data is used.
// - the digest key differs from the cipher key, both internal.
// - decrypted contents are checked with a CRC-CCITT checksum.
// - a fully checked update set requests reinitialization, unless its last segment is a key segment.
// - every segment of a set is checked before reinitializing.
// - a failing segment is dropped; current microcode stays.
// - one failure discards the whole set.
// - each failure is logged with a reason code.
// - key segments hold only new keys, checked with current keys.
`timescale 1ns/100ps
`default_nettype none
`include "sml_map.svh"
module sml_loader #(
    parameter int AW = 8,
    // initial keys: values arbitrary
    parameter logic [63:0] DES_KEY_INIT = 64'h5A5A_1234_C3C3_0F0F,
    parameter logic [63:0] MAC_KEY_INIT = 64'hA5A5_8765_3C3C_F0F0
) (
    input wire logic clk_sys, // core clock
    input wire logic rst_n, // async reset, active low
    input wire logic in_valid, // host beat offered
    output logic in_ready, // buffer has room
    input wire sml_pkg::sml_beat_s in_beat, // host beat
    output logic des_start, // start one block decryption
    output logic [63:0] des_key, // cipher key to engine
    output logic [63:0] des_in, // cipher block to engine
    input wire logic des_done, // engine result ready
    input wire logic [63:0] des_out, // engine result
    output logic mac_valid, // block for digest engine
    input wire logic mac_ready, // digest engine accepts
    output logic [63:0] mac_data, // block to digest
    output logic [63:0] mac_key, // digest key to engine
    output logic mac_fin, // segment ends, finish digest
    input wire logic mac_done, // digest result ready
    input wire logic [63:0] mac_digest, // computed digest
    output logic pt_valid, // plaintext block to staging
    input wire logic pt_ready, // staging accepts
    output logic [63:0] pt_data, // plaintext block
    output logic commit, // pulse: staged set is good
    output logic discard, // pulse: drop staged set
    output logic reinit_req, // pulse: reinitialize modem
    output logic fail_log, // pulse: segment failed
    output var sml_pkg::sml_code_t fail_code, // reason code of the last segment; a passing one leaves SML_CODE_LEN
    output logic [1:0] seg_status // bit1 done, bit0 pass
);
    function automatic logic [15:0] crc_blk(input logic [15:0] c,
                                            input logic [63:0] d);
        logic [15:0] r;
        logic fb;
        r = c;
        for (int i = 63; i >= 0; i--) begin
            fb = r[15] ^ d[i];
            r = {r[14:0], 1'b0};
            if (fb) begin
                r = r ^ `SML_CRC_POLY;
            end
        end
        return r;
    endfunction : crc_blk

    ////////////////////////////////////////////////////////////////////////
    // two-entry input buffer
    sml_pkg::sml_beat_s buf_q [0:1];
    logic wp_q, rp_q;
    logic [1:0] cnt_q;
    logic b_valid, b_ready, push, pop;
    sml_pkg::sml_beat_s b;
    assign in_ready = (cnt_q != 2'h2);
    assign push = in_valid && in_ready;
    assign b_valid = (cnt_q != 2'h0);
    assign b = buf_q[rp_q];
    assign pop = b_valid && b_ready;
    always_ff @(posedge clk_sys) begin
        if (push) begin
            buf_q[wp_q] <= in_beat;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            wp_q <= wp_q ^ push;
            rp_q <= rp_q ^ pop;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencing
    sml_pkg::sml_state_e st_q;
    logic [AW:0] wr_cnt_q, rd_idx_q;
    logic ovf_q, key_seg_q, set_last_q, seg_ok_q, set_fail_q;
    logic [63:0] digest_q, prev_q, cipher_q, plain_q, nk_des_q, nk_mac_q;
    logic [63:0] plain;
    logic [15:0] crc_q;
    logic is_last, auth_ok, mem_re, recv;
    logic [AW-1:0] mem_raddr;
    logic [63:0] mem_rdata;

    assign recv = (st_q == sml_pkg::SML_RECV);
    // nothing leaves the store before the digest matches
    assign b_ready = recv && (b.seg_last || mac_ready);
    assign mac_valid = recv && b_valid && !b.seg_last;
    assign mac_data = b.data;
    assign mac_fin = recv && pop && b.seg_last;
    assign auth_ok = (mac_digest == digest_q) && !ovf_q &&
                     (wr_cnt_q >= (AW+1)'(`SML_MIN_BLOCKS));
    // cipher block chaining, first stored block is the seed
    assign plain = des_out ^ prev_q;
    assign is_last = (rd_idx_q == wr_cnt_q - (AW+1)'(1));
    assign pt_valid = (st_q == sml_pkg::SML_EMIT) && !key_seg_q;
    assign pt_data = plain_q;
    assign des_in = cipher_q;
    assign mem_re = (st_q == sml_pkg::SML_AUTH && mac_done && auth_ok) ||
                    (st_q == sml_pkg::SML_SEED) ||
                    (st_q == sml_pkg::SML_EMIT && (pt_ready || key_seg_q));
    // read one word ahead: the store answers a cycle after the strobe
    assign mem_raddr = (st_q == sml_pkg::SML_AUTH) ? '0 :
                       (st_q == sml_pkg::SML_SEED) ? AW'(1) :
                       AW'(rd_idx_q + (AW+1)'(1));

    sml_seg_ram #(.W(`SML_BLK_W), .AW(AW)) u_ram (
        .clk_sys(clk_sys),
        .we(recv && pop && !b.seg_last && !ovf_q && !wr_cnt_q[AW]),
        .waddr(wr_cnt_q[AW-1:0]),
        .wdata(b.data),
        .re(mem_re),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= sml_pkg::SML_RECV;
            wr_cnt_q <= '0;
            rd_idx_q <= '0;
            ovf_q <= 1'b0;
            key_seg_q <= 1'b0;
            set_last_q <= 1'b0;
            seg_ok_q <= 1'b0;
            digest_q <= 64'h0;
            prev_q <= 64'h0;
            cipher_q <= 64'h0;
            plain_q <= 64'h0;
            crc_q <= `SML_CRC_INIT;
            des_start <= 1'b0;
            fail_code <= `SML_CODE_NONE;
            nk_des_q <= 64'h0;
            nk_mac_q <= 64'h0;
        end else begin
            des_start <= 1'b0;
            case (st_q)
                sml_pkg::SML_RECV: begin
                    if (pop && b.seg_last) begin
                        digest_q <= b.data;
                        key_seg_q <= b.key_seg;
                        set_last_q <= b.set_last;
                        st_q <= sml_pkg::SML_AUTH;
                    end else if (pop) begin
                        // oversize segment still drains, then fails
                        if (wr_cnt_q[AW]) begin
                            ovf_q <= 1'b1;
                        end else begin
                            wr_cnt_q <= wr_cnt_q + (AW+1)'(1);
                        end
                    end
                end
                sml_pkg::SML_AUTH: begin
                    if (mac_done) begin
                        if (auth_ok) begin
                            crc_q <= `SML_CRC_INIT;
                            st_q <= sml_pkg::SML_SEED;
                        end else begin
                            seg_ok_q <= 1'b0;
                            fail_code <= (mac_digest == digest_q) ?
                                         `SML_CODE_LEN : `SML_CODE_AUTH;
                            st_q <= sml_pkg::SML_END;
                        end
                    end
                end
                sml_pkg::SML_SEED: begin
                    prev_q <= mem_rdata;
                    rd_idx_q <= (AW+1)'(1);
                    st_q <= sml_pkg::SML_FETCH;
                end
                sml_pkg::SML_FETCH: begin
                    cipher_q <= mem_rdata;
                    des_start <= 1'b1;
                    st_q <= sml_pkg::SML_DES;
                end
                sml_pkg::SML_DES: begin
                    if (des_done) begin
                        prev_q <= cipher_q;
                        plain_q <= plain;
                        if (is_last) begin
                            // closing block carries the checksum
                            seg_ok_q <= (plain[15:0] == crc_q) &&
                                (!key_seg_q || wr_cnt_q ==
                                 (AW+1)'(`SML_KEY_BLOCKS + 2));
                            fail_code <= (plain[15:0] == crc_q) ?
                                         `SML_CODE_LEN : `SML_CODE_CRC;
                            st_q <= sml_pkg::SML_END;
                        end else begin
                            crc_q <= crc_blk(crc_q, plain);
                            if (rd_idx_q == (AW+1)'(1)) begin
                                nk_des_q <= plain;
                            end
                            if (rd_idx_q == (AW+1)'(2)) begin
                                nk_mac_q <= plain;
                            end
                            st_q <= sml_pkg::SML_EMIT;
                        end
                    end
                end
                sml_pkg::SML_EMIT: begin
                    if (pt_ready || key_seg_q) begin
                        rd_idx_q <= rd_idx_q + (AW+1)'(1);
                        st_q <= sml_pkg::SML_FETCH;
                    end
                end
                sml_pkg::SML_END: begin
                    wr_cnt_q <= '0;
                    ovf_q <= 1'b0;
                    st_q <= sml_pkg::SML_RECV;
                end
                default: begin
                    st_q <= sml_pkg::SML_RECV;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // set bookkeeping, keys and result pulses
    // keys drive only the engines; no host-facing port carries them
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            des_key <= DES_KEY_INIT;
            mac_key <= MAC_KEY_INIT;
        end else if (st_q == sml_pkg::SML_END && seg_ok_q && key_seg_q) begin
            des_key <= nk_des_q;
            mac_key <= nk_mac_q;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            set_fail_q <= 1'b0;
            commit <= 1'b0;
            discard <= 1'b0;
            reinit_req <= 1'b0;
            fail_log <= 1'b0;
            seg_status <= 2'h0;
        end else begin
            commit <= 1'b0;
            discard <= 1'b0;
            reinit_req <= 1'b0;
            fail_log <= 1'b0;
            if (st_q == sml_pkg::SML_END) begin
                seg_status <= {1'b1, seg_ok_q};
                fail_log <= !seg_ok_q;
                if (set_last_q) begin
                    set_fail_q <= 1'b0;
                    // one bad segment throws the set away
                    discard <= set_fail_q || !seg_ok_q;
                    commit <= !set_fail_q && seg_ok_q && !key_seg_q;
                    reinit_req <= !set_fail_q && seg_ok_q &&
                                  !key_seg_q;
                end else if (!seg_ok_q) begin
                    set_fail_q <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    chk_no_early_use: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st_q == sml_pkg::SML_AUTH && !mac_done) |=> !des_start && !pt_valid)
        else $error("data used before digest match");
    chk_auth_fail_drop: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        (st_q == sml_pkg::SML_AUTH && mac_done && mac_digest != digest_q)
        |=> ##1 fail_log && !commit && !reinit_req)
        else $error("bad digest not dropped");
    chk_reinit_commit: assert property (@(posedge clk_sys)
        disable iff (!rst_n) reinit_req |-> commit && !discard)
        else $error("reinit without commit");
    chk_set_discard: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        (st_q == sml_pkg::SML_END && set_last_q && set_fail_q)
        |=> discard && !reinit_req)
        else $error("failed set not discarded");
    chk_fail_logged: assert property (@(posedge clk_sys)
        disable iff (!rst_n) fail_log |-> seg_status == 2'h2 &&
        fail_code != `SML_CODE_NONE)
        else $error("failure without reason");
    chk_crc_preset: assert property (@(posedge clk_sys)
        disable iff (!rst_n) (st_q == sml_pkg::SML_SEED)
        |-> crc_q == `SML_CRC_INIT)
        else $error("checksum not preset");
    chk_chain_seed: assert property (@(posedge clk_sys)
        disable iff (!rst_n) (st_q == sml_pkg::SML_SEED)
        |=> prev_q == $past(mem_rdata))
        else $error("chain not seeded");
    chk_crc_verdict: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        (st_q == sml_pkg::SML_DES && des_done && is_last &&
         plain[15:0] != crc_q) |=> ##1 fail_log)
        else $error("checksum mismatch passed");
    chk_key_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st_q != sml_pkg::SML_END) |=> $stable(des_key) && $stable(mac_key))
        else $error("keys changed outside key segment");
endmodule : sml_loader
`default_nettype wire

/* tb/sml_engine_model.sv */
// stand-in for the cipher and digest engines beside the loader
// assumes one clock; the cipher is a key xor so the bench can predict it
`timescale 1ns/100ps
`default_nettype none
module sml_engine_model (
    input wire logic clk_sys, // core clock
    input wire logic rst_n, // async reset, active low
    input wire logic des_start, // block start
    input wire logic [63:0] des_key, // cipher key
    input wire logic [63:0] des_in, // cipher block
    output logic des_done, // result pulse
    output logic [63:0] des_out, // result
    input wire logic mac_valid, // digest block offered
    output logic mac_ready, // digest block taken
    input wire logic [63:0] mac_data, // digest block
    input wire logic [63:0] mac_key, // digest key
    input wire logic mac_fin, // finish digest
    output logic mac_done, // digest pulse
    output logic [63:0] mac_digest // digest
);
    logic [2:0] wait_q;
    logic [63:0] res_q;
    logic [63:0] acc_q;
    logic [1:0] cyc_q;
    logic slow_q;
    // every fourth cycle stalls the digest side, so the buffer fills
    assign mac_ready = (cyc_q != 2'h3);
    ////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys or negedge rst_n) begin
        des_done <= 1'b0;
        mac_done <= 1'b0;
        // stale results flip so nothing reads a held value by luck
        des_out <= ~des_out;
        mac_digest <= ~mac_digest;
        cyc_q <= cyc_q + 2'h1;
        if (!rst_n) begin
            wait_q <= 3'h0;
            acc_q <= 64'h0;
            cyc_q <= 2'h0;
            slow_q <= 1'b0;
            des_out <= 64'h0;
            mac_digest <= 64'h0;
        end else begin
            if (des_start) begin
                // prompt and slow answers alternate
                wait_q <= slow_q ? 3'h5 : 3'h1;
                slow_q <= ~slow_q;
                res_q <= des_in ^ des_key;
            end else if (wait_q != 3'h0) begin
                wait_q <= wait_q - 3'h1;
                des_done <= (wait_q == 3'h1);
                if (wait_q == 3'h1) des_out <= res_q;
            end
            if (mac_valid && mac_ready) acc_q <= {acc_q[62:0], acc_q[63]} ^ mac_data;
            if (mac_fin) begin
                mac_done <= 1'b1;
                mac_digest <= acc_q ^ mac_key;
                acc_q <= 64'h0;
            end
        end
    end
endmodule : sml_engine_model
`default_nettype wire

/* tb/sml_loader_tb.sv */
// bench for the secure microcode loader: builds encrypted segments,
// streams them in and judges plaintext, pulses and status
// assumes sml_engine_model answers for the cipher and digest engines
`timescale 1ns/100ps
`default_nettype none
module sml_loader_tb;
    localparam logic [63:0] KD0 = 64'h0123_4567_89AB_CDEF;
    localparam logic [63:0] KM0 = 64'hFEDC_BA98_7654_3210;
    logic clk_sys, rst_n, in_valid, in_ready, pt_valid, pt_ready;
    logic des_start, des_done, mac_valid, mac_ready, mac_fin, mac_done;
    logic commit, discard, reinit_req, fail_log;
    logic [63:0] des_key, des_in, des_out, mac_data, mac_key, mac_digest;
    logic [63:0] pt_data, kd, km, seed_q;
    logic [63:0] pd[0:7];
    logic [63:0] pt_q[$];
    logic [1:0] seg_status, cyc;
    sml_pkg::sml_beat_s in_beat;
    sml_pkg::sml_code_t fail_code;
    int failures = 0, compares = 0, n_c = 0, n_d = 0, n_r = 0, n_f = 0;
    int b_c, b_d, b_r, b_f;
    sml_loader #(.AW(3), .DES_KEY_INIT(KD0), .MAC_KEY_INIT(KM0)) sml_loader_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .in_valid(in_valid),
        .in_ready(in_ready), .in_beat(in_beat), .des_start(des_start),
        .des_key(des_key), .des_in(des_in), .des_done(des_done),
        .des_out(des_out), .mac_valid(mac_valid), .mac_ready(mac_ready),
        .mac_data(mac_data), .mac_key(mac_key), .mac_fin(mac_fin),
        .mac_done(mac_done), .mac_digest(mac_digest), .pt_valid(pt_valid),
        .pt_ready(pt_ready), .pt_data(pt_data), .commit(commit),
        .discard(discard), .reinit_req(reinit_req), .fail_log(fail_log),
        .fail_code(fail_code), .seg_status(seg_status));
    sml_engine_model sml_engine_model_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .des_start(des_start),
        .des_key(des_key), .des_in(des_in), .des_done(des_done),
        .des_out(des_out), .mac_valid(mac_valid), .mac_ready(mac_ready),
        .mac_data(mac_data), .mac_key(mac_key), .mac_fin(mac_fin),
        .mac_done(mac_done), .mac_digest(mac_digest));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////
    // staging stalls one cycle in four; monitor tallies every pulse
    always @(posedge clk_sys) begin
        cyc <= cyc + 2'h1;
        pt_ready <= (cyc != 2'h1);
        if (pt_valid === 1'b1 && pt_ready === 1'b1) pt_q.push_back(pt_data);
        n_c += (commit === 1'b1);
        n_d += (discard === 1'b1);
        n_r += (reinit_req === 1'b1);
        n_f += (fail_log === 1'b1);
    end
    task automatic end_of_test;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string what, input logic [63:0] exp,
            input logic [63:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic stall_out(input string what);
        failures++;
        $display("mismatch %s expected progress seen timeout", what);
        end_of_test();
    endtask : stall_out
    function automatic logic [15:0] crc_blk(input logic [15:0] c,
            input logic [63:0] d);
        for (int i = 63; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
        return c;
    endfunction : crc_blk
    ////////////////////////////////////////////////////////////////////
    task automatic put_beat(input logic [63:0] d, input logic sl, st, ks);
        int k;
        k = 0;
        in_valid <= 1'b1;
        in_beat <= '{data: d, seg_last: sl, set_last: st, key_seg: ks};
        do begin
            @(posedge clk_sys);
            k++;
        end while (in_ready !== 1'b1 && k < 300);
        if (k >= 300) stall_out("input");
    endtask : put_beat
    task automatic send_seg(input int n, input logic [15:0] bad_crc,
            input logic [63:0] bad_dig, input logic st, ks, short_seg);
        logic [63:0] blk[$];
        logic [63:0] prev, acc;
        logic [15:0] crc;
        seed_q = {seed_q[62:0], seed_q[63]} ^ 64'h9E37_79B9_7F4A_7C15;
        blk.push_back(seed_q);
        prev = seed_q;
        crc = 16'hFFFF;
        for (int i = 0; i < n; i++) begin
            crc = crc_blk(crc, pd[i]);
            prev = pd[i] ^ prev ^ kd;
            blk.push_back(prev);
        end
        // zero fill above the checksum keeps the block whole
        if (!short_seg) blk.push_back({48'h0, crc ^ bad_crc} ^ prev ^ kd);
        acc = 64'h0;
        @(posedge clk_sys);
        foreach (blk[i]) begin
            acc = {acc[62:0], acc[63]} ^ blk[i];
            put_beat(blk[i], 1'b0, 1'b0, 1'b0);
        end
        put_beat(acc ^ km ^ bad_dig, 1'b1, st, ks);
        in_valid <= 1'b0;
        in_beat <= sml_pkg::sml_beat_s'(~in_beat);
        @(posedge clk_sys);
    endtask : send_seg
    task automatic wait_on(input bit fails, input int tgt);
        int k;
        k = 0;
        while ((fails ? n_f - b_f : n_c + n_d - b_c - b_d) < tgt) begin
            @(posedge clk_sys);
            k++;
            if (k > 5000) stall_out("result");
        end
        repeat (2) @(posedge clk_sys);
    endtask : wait_on
    task automatic fresh;
        b_c = n_c;
        b_d = n_d;
        b_r = n_r;
        b_f = n_f;
        pt_q.delete();
    endtask : fresh
    task automatic tally(input int c, d, f);
        chk("commit", 64'(c), 64'(n_c - b_c));
        chk("reinit", 64'(c), 64'(n_r - b_r));
        chk("discard", 64'(d), 64'(n_d - b_d));
        chk("fail log", 64'(f), 64'(n_f - b_f));
    endtask : tally
    ////////////////////////////////////////////////////////////////////
    task automatic t_single_pass;
        fresh();
        send_seg(3, 16'h0, 64'h0, 1'b1, 1'b0, 1'b0);
        wait_on(1'b0, 1);
        tally(1, 0, 0);
        chk("staged", 64'd3, 64'(pt_q.size()));
        for (int i = 0; i < 3; i++) chk("plain", pd[i], pt_q[i]);
        chk("status", 64'h3, 64'(seg_status));
    endtask : t_single_pass
    task automatic t_bad_digest;
        fresh();
        send_seg(2, 16'h0, 64'h1, 1'b1, 1'b0, 1'b0);
        wait_on(1'b0, 1);
        tally(0, 1, 1);
        chk("staged", 64'd0, 64'(pt_q.size()));
        chk("code", 64'h1, 64'(fail_code));
        chk("status", 64'h2, 64'(seg_status));
    endtask : t_bad_digest
    task automatic t_bad_crc;
        fresh();
        send_seg(2, 16'h0001, 64'h0, 1'b1, 1'b0, 1'b0);
        wait_on(1'b0, 1);
        tally(0, 1, 1);
        chk("code", 64'h2, 64'(fail_code));
    endtask : t_bad_crc
    task automatic t_set_one_bad;
        fresh();
        send_seg(2, 16'h8000, 64'h0, 1'b0, 1'b0, 1'b0);
        wait_on(1'b1, 1);
        send_seg(1, 16'h0, 64'h0, 1'b1, 1'b0, 1'b0);
        wait_on(1'b0, 1);
        tally(0, 1, 1);
    endtask : t_set_one_bad
    task automatic t_set_all_pass;
        fresh();
        send_seg(2, 16'h0, 64'h0, 1'b0, 1'b0, 1'b0);
        send_seg(0, 16'h0, 64'h0, 1'b1, 1'b0, 1'b0);
        wait_on(1'b0, 1);
        tally(1, 0, 0);
        for (int i = 0; i < 2; i++) chk("plain", pd[i], pt_q[i]);
    endtask : t_set_all_pass
    task automatic t_short;
        fresh();
        send_seg(0, 16'h0, 64'h0, 1'b1, 1'b0, 1'b1);
        wait_on(1'b0, 1);
        tally(0, 1, 1);
        chk("code", 64'h3, 64'(fail_code));
    endtask : t_short
    task automatic t_key_swap;
        int k;
        fresh();
        pd[0] = 64'h3C3C_1111_2222_7E7E;
        pd[1] = 64'hC3C3_4444_5555_8181;
        send_seg(2, 16'h0, 64'h0, 1'b1, 1'b1, 1'b0);
        k = 0;
        while (mac_key !== pd[1] && k < 3000) begin
            @(posedge clk_sys);
            k++;
        end
        if (k >= 3000) stall_out("key swap");
        repeat (2) @(posedge clk_sys);
        chk("digest key", pd[1], mac_key);
        chk("cipher key", pd[0], des_key);
        chk("staged", 64'd0, 64'(pt_q.size()));
        tally(0, 0, 0);
        kd = pd[0];
        km = pd[1];
    endtask : t_key_swap
    ////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        in_valid = 1'b0;
        in_beat = '0;
        pt_ready = 1'b0;
        cyc = 2'h0;
        kd = KD0;
        km = KM0;
        seed_q = 64'h6A09_E667_F3BC_C908;
        for (int i = 0; i < 8; i++) pd[i] = 64'(64'h0F1E_2D3C_4B5A_6978 * (i + 1));
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        chk("ready", 64'h1, 64'(in_ready));
        chk("status", 64'h0, 64'(seg_status));
        chk("digest key", KM0, mac_key);
        t_single_pass();
        t_bad_digest();
        t_bad_crc();
        t_set_one_bad();
        t_set_all_pass();
        t_short();
        t_key_swap();
        t_single_pass();
        end_of_test();
    end
endmodule : sml_loader_tb
`default_nettype wire
